/* File: common/cfe_pkg.sv */
// package of constants and types for the codec front end
package cfe_pkg;
	// ----------------------------------------
	// code bus
	// ----------------------------------------
	localparam int CODE_W = 8;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	// bytes of free room below which hold is raised in compression
	localparam logic [7:0] HOLD_ROOM_MIN = 8'h03;
	// bytes of fill below which hold is raised in decompression
	localparam logic [7:0] HOLD_FILL_MIN = 8'h03;
	// ----------------------------------------
	// codec command
	// ----------------------------------------
	localparam logic [9:0] LAUNCH_ADDR = 10'h000;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ----------------------------------------
	// launch states
	// ----------------------------------------
	typedef enum logic [2:0] {
		CFE_L_IDLE = 3'b001,
		CFE_L_REQ = 3'b010,
		CFE_L_WAIT = 3'b100
	} cfe_launch_t;
endpackage

/* File: tb/cfe_codec_model.sv */
// behavioural codec acting as code bus master
`timescale 1ns/1ps
module cfe_codec_model (
	// link
	input wire logic vclk,
	input wire logic hold_n,
	input wire logic run,
	// code bus
	output logic cs_n,
	output logic [7:0] code,
	output logic [7:0] sent
);
	initial begin
		cs_n = 1'b1;
		code = 8'h00;
		sent = 8'h00;
	end
	// one byte per rising edge while hold was clear the cycle before
	always @(posedge vclk) begin
		if (run && hold_n) begin
			cs_n <= 1'b0;
			code <= sent;
			sent <= sent + 8'h01;
		end else begin
			cs_n <= 1'b1;
			code <= ~code;
		end
	end
endmodule

/* File: tb/tb.sv */
// self-checking testbench for the codec front end
`timescale 1ns/1ps
module tb;
	logic clk, reset, mode, vclk, run, cs_n, oe_n, hold_n, end_n, done, done_clr;
	logic push_valid, push_ready, pop_valid, pop_ready, go_en, go_req, wr_valid, wr_ready;
	logic [7:0] code_in, code_out, push_data, room, pop_data, fill, sent, exp_byte, gdata;
	logic [2:0] gsel, greg, wsel, wreg;
	logic [1:0] gaddr;
	int num_errors = 0;
	int comparisons = 0;
	cfe_front_end i_cfe_front_end (.clk(clk), .reset(reset), .decompress_mode(mode),
		.double_rate_video_clock(vclk), .codec_cycle_select_n(cs_n), .code_in(code_in),
		.code_out(code_out), .code_oe_n(oe_n), .codec_hold_n(hold_n), .codec_end_n(end_n),
		.push_data(push_data), .push_valid(push_valid), .push_ready(push_ready),
		.fifo_room(room), .pop_data(pop_data), .pop_valid(pop_valid), .pop_ready(pop_ready),
		.fifo_fill(fill), .field_done_latched(done), .field_done_clear(done_clr),
		.launch_enable(go_en), .launch_request(go_req), .launch_guest_select(gsel),
		.launch_guest_register(greg), .guest_wr_valid(wr_valid), .guest_wr_ready(wr_ready),
		.guest_wr_select(wsel), .guest_wr_register(wreg), .guest_addr_lines(gaddr),
		.guest_data_bus(gdata));
	cfe_codec_model i_cfe_codec_model (.vclk(vclk), .hold_n(hold_n), .run(run), .cs_n(cs_n),
		.code(code_in), .sent(sent));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		vclk = 1'b0;
		#3;
		forever #32 vclk = ~vclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ---------------------------------
	// byte order into the fifo
	// ---------------------------------
	always @(posedge clk) begin
		if (push_valid === 1'b1 && push_ready === 1'b1 && mode === 1'b0) begin
			check(push_data, exp_byte);
			exp_byte <= exp_byte + 8'h01;
		end
	end
	initial begin
		int i, j;
		{reset, mode, run, end_n, done_clr, push_ready, pop_valid} = 7'h41;
		{go_en, go_req, wr_ready, room, pop_data, fill, gsel, greg} = 33'h0;
		end_n = 1'b1;
		exp_byte = 8'h00;
		void'($urandom(32'ha923));
		cycles(5);
		@(negedge clk);
		check(hold_n, 8'h00);
		check(oe_n, 8'h01);
		cycles(1);
		// compression burst with a receiver stall
		reset <= 1'b0;
		room <= 8'h40;
		push_ready <= 1'b1;
		run <= 1'b1;
		cycles(200);
		push_ready <= 1'b0;
		cycles(100);
		@(negedge clk);
		check(hold_n, 8'h00);
		cycles(1);
		push_ready <= 1'b1;
		cycles(100);
		room <= 8'($urandom % 3);
		cycles(100);
		@(negedge clk);
		check(hold_n, 8'h00);
		cycles(1);
		room <= 8'h40;
		cycles(4);
		@(negedge clk);
		check(hold_n, 8'h01);
		cycles(1);
		run <= 1'b0;
		cycles(60);
		check(exp_byte, sent);
		// decompression burst
		mode <= 1'b1;
		fill <= 8'h40;
		pop_data <= 8'($urandom);
		pop_valid <= 1'b1;
		run <= 1'b1;
		cycles(100);
		@(negedge clk);
		check(oe_n, 8'h00);
		check(code_out, pop_data);
		cycles(1);
		fill <= 8'h02;
		cycles(4);
		@(negedge clk);
		check(hold_n, 8'h00);
		cycles(40);
		run <= 1'b0;
		fill <= 8'h40;
		cycles(40);
		@(negedge clk);
		check(hold_n, 8'h01);
		check(oe_n, 8'h01);
		cycles(1);
		// end of field
		end_n <= 1'b0;
		cycles(2);
		end_n <= 1'b1;
		cycles(4);
		@(negedge clk);
		check(done, 8'h01);
		cycles(1);
		done_clr <= 1'b1;
		cycles(1);
		done_clr <= 1'b0;
		cycles(2);
		@(negedge clk);
		check(done, 8'h00);
		// launch requested while disabled, run on enable
		for (j = 0; j < 2; j++) begin
			cycles(1);
			gsel <= 3'($urandom);
			greg <= 3'($urandom);
			go_en <= 1'b0;
			go_req <= 1'b1;
			cycles(1);
			go_req <= 1'b0;
			cycles(20);
			@(negedge clk);
			check(wr_valid, 8'h00);
			cycles(1);
			go_en <= 1'b1;
			for (i = 0; i < 20 && wr_valid !== 1'b1; i++) @(negedge clk);
			if (i == 20) begin
				num_errors++;
				complete_run();
			end
			check(wsel, gsel);
			check(wreg, greg);
			check({6'h00, gaddr}, {6'h00, cfe_pkg::LAUNCH_ADDR[9:8]});
			check(gdata, cfe_pkg::LAUNCH_ADDR[7:0]);
			cycles(1);
			wr_ready <= 1'b1;
			cycles(1);
			wr_ready <= 1'b0;
			cycles(2);
			@(negedge clk);
			check(wr_valid, 8'h00);
		end
		complete_run();
	end
endmodule

/* File: verilog/cfe_front_end.sv */
// codec front end: code bus byte mover, hold flow control, launch and field done
`timescale 1ns/1ps
module cfe_front_end (
	input wire logic clk,
	input wire logic reset,
	// mode
	input wire logic decompress_mode,
	// code bus pins
	input wire logic double_rate_video_clock,
	input wire logic codec_cycle_select_n,
	input wire logic [7:0] code_in,
	output logic [7:0] code_out,
	output logic code_oe_n,
	output logic codec_hold_n,
	input wire logic codec_end_n,
	// code fifo, compression direction
	output logic [7:0] push_data,
	output logic push_valid,
	input wire logic push_ready,
	input wire logic [7:0] fifo_room,
	// code fifo, decompression direction
	input wire logic [7:0] pop_data,
	input wire logic pop_valid,
	output logic pop_ready,
	input wire logic [7:0] fifo_fill,
	// field done flag
	output logic field_done_latched,
	input wire logic field_done_clear,
	// launch control
	input wire logic launch_enable,
	input wire logic launch_request,
	input wire logic [2:0] launch_guest_select,
	input wire logic [2:0] launch_guest_register,
	// guest write request to the guest bus master
	output logic guest_wr_valid,
	input wire logic guest_wr_ready,
	output logic [2:0] guest_wr_select,
	output logic [2:0] guest_wr_register,
	output logic [1:0] guest_addr_lines,
	output logic [7:0] guest_data_bus
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] vclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] end_sync_reg;
	logic [7:0] data_sync1_reg;
	logic [7:0] data_sync2_reg;
	logic vclk_prev_reg;
	logic rise;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vclk_sync_reg <= 2'h0;
			cs_sync_reg <= 2'h3;
			end_sync_reg <= 2'h3;
			data_sync1_reg <= cfe_pkg::RESET_BYTE;
			data_sync2_reg <= cfe_pkg::RESET_BYTE;
			vclk_prev_reg <= 1'b0;
		end else begin
			vclk_sync_reg <= {vclk_sync_reg[0], double_rate_video_clock};
			cs_sync_reg <= {cs_sync_reg[0], codec_cycle_select_n};
			end_sync_reg <= {end_sync_reg[0], codec_end_n};
			data_sync1_reg <= code_in;
			data_sync2_reg <= data_sync1_reg;
			vclk_prev_reg <= vclk_sync_reg[1];
		end
	end
	// rising edge of the link clock, seen in the clk domain
	assign rise = vclk_sync_reg[1] & ~vclk_prev_reg;
	// ----------------------------------------
	// two-entry buffer in the data path
	// ----------------------------------------
	logic [7:0] buf_mem [0:1];
	logic buf_wptr_reg;
	logic buf_rptr_reg;
	logic [1:0] buf_count_reg;
	logic buf_in_valid;
	logic [7:0] buf_in_data;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic cap;
	logic take;
	assign buf_in_ready = (buf_count_reg != cfe_pkg::BUF_DEPTH);
	assign buf_out_valid = (buf_count_reg != 2'h0);
	// compression capture: rising edge while cycle select active
	assign cap = ~decompress_mode & rise & ~cs_sync_reg[1];
	// decompression: one byte per link clock rising edge while select active
	assign take = decompress_mode & rise & ~cs_sync_reg[1];
	assign buf_in_valid = decompress_mode ? (pop_valid & pop_ready) : cap;
	assign buf_in_data = decompress_mode ? pop_data : data_sync2_reg;
	// in compression pop only on the cycle that launches a push pulse, in decompression on take, so no byte is skipped
	assign buf_out_ready = decompress_mode ? take : (push_ready & ~push_valid);
	always_ff @(posedge clk) begin
		if (buf_in_valid && buf_in_ready) begin
			buf_mem[buf_wptr_reg] <= buf_in_data;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			buf_wptr_reg <= 1'b0;
			buf_rptr_reg <= 1'b0;
			buf_count_reg <= 2'h0;
		end else begin
			if (buf_in_valid && buf_in_ready) begin
				buf_wptr_reg <= ~buf_wptr_reg;
			end
			if (buf_out_valid && buf_out_ready) begin
				buf_rptr_reg <= ~buf_rptr_reg;
			end
			buf_count_reg <= buf_count_reg + {1'b0, buf_in_valid & buf_in_ready}
				- {1'b0, buf_out_valid & buf_out_ready};
		end
	end
	// ----------------------------------------
	// fifo side and bus drive
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			push_valid <= 1'b0;
			push_data <= cfe_pkg::RESET_BYTE;
			pop_ready <= 1'b0;
			code_out <= cfe_pkg::RESET_BYTE;
			code_oe_n <= 1'b1;
		end else begin
			// single pulse per byte toward the fifo
			push_valid <= ~decompress_mode & buf_out_valid & push_ready & ~push_valid;
			if (~decompress_mode && buf_out_valid) begin
				push_data <= buf_mem[buf_rptr_reg];
			end
			pop_ready <= decompress_mode & (buf_count_reg == 2'h0) & ~pop_ready;
			// drivers on only while select active in decompression
			code_oe_n <= ~(decompress_mode & ~cs_sync_reg[1]);
			if (take && buf_out_valid) begin
				code_out <= buf_mem[buf_rptr_reg];
			end
		end
	end
	// ----------------------------------------
	// hold flow control
	// ----------------------------------------
	logic hold_next;
	always_comb begin
		if (decompress_mode) begin
			hold_next = (fifo_fill < cfe_pkg::HOLD_FILL_MIN);
		end else begin
			hold_next = (fifo_room < cfe_pkg::HOLD_ROOM_MIN) | ~buf_in_ready;
		end
	end
	// margin of several bytes covers the lookahead the codec uses
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			codec_hold_n <= 1'b0;
		end else begin
			codec_hold_n <= ~hold_next;
		end
	end
	// ----------------------------------------
	// field done latch
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			field_done_latched <= 1'b0;
		end else if (~end_sync_reg[1]) begin
			field_done_latched <= 1'b1;
		end else if (field_done_clear) begin
			field_done_latched <= 1'b0;
		end
	end
	// ----------------------------------------
	// automatic launch
	// ----------------------------------------
	cfe_pkg::cfe_launch_t launch_reg;
	logic pending_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pending_reg <= 1'b0;
		end else if (launch_request) begin
			pending_reg <= 1'b1;
		end else if (launch_reg == cfe_pkg::CFE_L_REQ && guest_wr_ready) begin
			pending_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			launch_reg <= cfe_pkg::CFE_L_IDLE;
			guest_wr_valid <= 1'b0;
			guest_wr_select <= 3'h0;
			guest_wr_register <= 3'h0;
			guest_addr_lines <= 2'h0;
			guest_data_bus <= cfe_pkg::RESET_BYTE;
		end else begin
			case (launch_reg)
				cfe_pkg::CFE_L_IDLE: begin
					if (pending_reg && launch_enable) begin
						guest_wr_valid <= 1'b1;
						guest_wr_select <= launch_guest_select;
						guest_wr_register <= launch_guest_register;
						guest_addr_lines <= cfe_pkg::LAUNCH_ADDR[9:8];
						guest_data_bus <= cfe_pkg::LAUNCH_ADDR[7:0];
						launch_reg <= cfe_pkg::CFE_L_REQ;
					end
				end
				cfe_pkg::CFE_L_REQ: begin
					if (guest_wr_ready) begin
						guest_wr_valid <= 1'b0;
						launch_reg <= cfe_pkg::CFE_L_WAIT;
					end
				end
				cfe_pkg::CFE_L_WAIT: begin
					launch_reg <= cfe_pkg::CFE_L_IDLE;
				end
				default: begin
					guest_wr_valid <= 1'b0;
					launch_reg <= cfe_pkg::CFE_L_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	launch_gate_a: assert property (@(posedge clk) disable iff (reset)
		$rose(guest_wr_valid) |-> $past(launch_enable))
		else $error("launch issued while disabled");
	launch_addr_a: assert property (@(posedge clk) disable iff (reset)
		guest_wr_valid |-> (guest_addr_lines == 2'h0 && guest_data_bus == 8'h00))
		else $error("launch address not zero");
	launch_kept_a: assert property (@(posedge clk) disable iff (reset)
		(launch_request && !launch_enable) |=> pending_reg)
		else $error("disabled launch lost");
	field_done_a: assert property (@(posedge clk) disable iff (reset)
		!end_sync_reg[1] |=> field_done_latched)
		else $error("field end not latched");
	drive_gate_a: assert property (@(posedge clk) disable iff (reset)
		(!decompress_mode) |=> code_oe_n)
		else $error("bus driven in compression");
	capture_sel_a: assert property (@(posedge clk) disable iff (reset)
		(!decompress_mode && rise && cs_sync_reg[1]) |=> $stable(buf_wptr_reg))
		else $error("capture without select");
	hold_full_a: assert property (@(posedge clk) disable iff (reset)
		(!decompress_mode && fifo_room < 8'h03) |=> !codec_hold_n)
		else $error("hold not raised near full");
	hold_free_a: assert property (@(posedge clk) disable iff (reset)
		(decompress_mode && fifo_fill >= 8'h03) |=> codec_hold_n)
		else $error("hold not released");
	sequence take_s;
		take && buf_out_valid;
	endsequence
	sequence launch_done_s;
		guest_wr_valid && guest_wr_ready;
	endsequence
	push_pulse_a: assert property (@(posedge clk) disable iff (reset)
		push_valid |=> !push_valid)
		else $error("push valid longer than one cycle");
	pop_pulse_a: assert property (@(posedge clk) disable iff (reset)
		pop_ready |=> !pop_ready)
		else $error("pop ready longer than one cycle");
	code_drive_a: assert property (@(posedge clk) disable iff (reset)
		take_s |=> (code_out == $past(buf_mem[buf_rptr_reg])))
		else $error("code byte not presented");
	drive_sel_a: assert property (@(posedge clk) disable iff (reset)
		(decompress_mode && !cs_sync_reg[1]) |=> !code_oe_n)
		else $error("bus not driven under select");
	hold_buf_a: assert property (@(posedge clk) disable iff (reset)
		(!decompress_mode && !buf_in_ready) |=> !codec_hold_n)
		else $error("hold not raised on full buffer");
	launch_end_a: assert property (@(posedge clk) disable iff (reset)
		launch_done_s |=> (!guest_wr_valid && launch_reg == cfe_pkg::CFE_L_WAIT))
		else $error("launch write not ended");
	launch_clr_a: assert property (@(posedge clk) disable iff (reset)
		(launch_done_s && !launch_request) |=> !pending_reg)
		else $error("pending launch not cleared");
	done_wins_a: assert property (@(posedge clk) disable iff (reset)
		(!end_sync_reg[1] && field_done_clear) |=> field_done_latched)
		else $error("clear beat field end");
endmodule
